/* File: verilog/crr_pkg.sv */
// constants for the core register reset and wake initialisation block
package crr_pkg;

    localparam int          NREG    = 22;
    localparam int          NSRC    = 11;
    localparam int          ADDR_W  = 8;
    localparam int          PC_W    = 21;

    // register word indices; byte address is index times four
    localparam logic [4:0]  IDX_STACK_TOP_UPPER     = 5'h00;
    localparam logic [4:0]  IDX_STACK_TOP_HIGH      = 5'h01;
    localparam logic [4:0]  IDX_STACK_TOP_LOW       = 5'h02;
    localparam logic [4:0]  IDX_RETURN_STACK_PTR    = 5'h03;
    localparam logic [4:0]  IDX_PC_LATCH_UPPER      = 5'h04;
    localparam logic [4:0]  IDX_PC_LATCH_HIGH       = 5'h05;
    localparam logic [4:0]  IDX_PROG_COUNTER_LOW    = 5'h06;
    localparam logic [4:0]  IDX_TABLE_PTR_HIGH      = 5'h08;
    localparam logic [4:0]  IDX_WORKING_ACC         = 5'h12;
    localparam logic [4:0]  IDX_IRQ_CONTROL_MAIN    = 5'h0D;
    localparam logic [4:0]  IDX_IRQ_CONTROL_SECOND  = 5'h0E;
    localparam logic [4:0]  IDX_IRQ_CONTROL_THIRD   = 5'h0F;
    localparam logic [4:0]  IDX_INDIRECT_PTR0_HIGH  = 5'h10;
    localparam logic [7:0]  ADDR_EVENT_STATUS       = 8'h60;
    localparam logic [7:0]  ADDR_EVENT_MASK         = 8'h64;

    // reset source bit positions
    localparam int SRC_POWER_ON    = 0;
    localparam int SRC_BROWN_OUT   = 1;
    localparam int SRC_DEEP_SLEEP  = 2;
    localparam int SRC_PIN         = 3;
    localparam int SRC_WDT         = 4;
    localparam int SRC_RST_INSTR   = 5;
    localparam int SRC_STACK_FULL  = 6;
    localparam int SRC_STACK_UNDER = 7;
    localparam int SRC_CFG_MISMATCH = 8;
    localparam int SRC_WDT_WAKE    = 9;
    localparam int SRC_IRQ_WAKE    = 10;

    localparam logic [10:0] POWER_SRC_MASK = 11'h007;
    localparam logic [10:0] WARM_SRC_MASK  = 11'h1F8;
    localparam logic [10:0] WAKE_SRC_MASK  = 11'h600;

    // irq control main: bit 7 high enable, bit 6 low enable
    localparam int GIE_HIGH_BIT = 7;
    localparam int GIE_LOW_BIT  = 6;

    localparam logic [20:0] VEC_HIGH = 21'h000008;
    localparam logic [20:0] VEC_LOW  = 21'h000018;
    localparam logic [20:0] PC_STEP  = 21'h000002;

    // event status bits
    localparam int EV_POWER  = 0;
    localparam int EV_WARM   = 1;
    localparam int EV_WAKE   = 2;
    localparam int EV_VECTOR = 3;

    localparam logic [7:0] REG_RESET [NREG] = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hC0,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] REG_MASK [NREG] = '{
        8'h1F, 8'hFF, 8'hFF, 8'hDF, 8'h1F, 8'hFF, 8'hFF, 8'h3F,
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'h0F, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'h0F};
    // bits a power class leaves alone (undefined contents)
    localparam logic [7:0] POWER_KEEP [NREG] = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h01, 8'h00, 8'h00,
        8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h00};
    // bits a warm class preserves
    localparam logic [7:0] WARM_KEEP [NREG] = '{
        8'h00, 8'h00, 8'h00, 8'hC0, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h01, 8'h00, 8'h00,
        8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h00};

    typedef enum logic [3:0] {
        CLS_NONE  = 4'b0001,
        CLS_POWER = 4'b0010,
        CLS_WARM  = 4'b0100,
        CLS_WAKE  = 4'b1000
    } crr_class_t;

endpackage : crr_pkg

/* File: verilog/crr_core_regs.sv */
// core register bank with reset class and wake initialisation, apb slave
`timescale 1ns/1ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// Function
// - three init classes: power, warm, wake
// - vectored wake pushes pc, bumps stack pointer
// - vectored wake loads high or low vector
// - power/warm clear pc low; non-vectored wake pc plus two
// - wake records cause bits in irq control
// - irq control main: clear 7..1, bit0 special
// - irq control second ones on power/warm
// - irq control third 0xC0 on power/warm
// - stack pointer: power clears, warm keeps flags
// - pc latch upper, stack top upper clear
// - table pointers and latch clear, wake keeps
// - product, working, pointer low keep contents
// - pointer high and bank select clear
// - indirect ports have no storage
module crr_core_regs (
    input  wire logic                 core_clk,
    input  wire logic                 nrst,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [10:0]          rst_src,
    input  wire logic [20:0]          wake_pc,
    input  wire logic                 wake_high_prio,
    input  wire logic [7:0]           wake_irq_flags,
    output logic      [20:0]          pc_out,
    output crr_pkg::crr_class_t       class_out,
    output logic                      irq
);

    //////////////////////////////////////////////////////////////////////////
    function automatic crr_pkg::crr_class_t decode_class(
        input logic [10:0] src
    );
        // power outranks warm outranks wake, so only one ever applies
        if ((src & crr_pkg::POWER_SRC_MASK) != 11'h000) begin
            return crr_pkg::CLS_POWER;
        end
        if ((src & crr_pkg::WARM_SRC_MASK) != 11'h000) begin
            return crr_pkg::CLS_WARM;
        end
        if ((src & crr_pkg::WAKE_SRC_MASK) != 11'h000) begin
            return crr_pkg::CLS_WAKE;
        end
        return crr_pkg::CLS_NONE;
    endfunction : decode_class

    function automatic logic [7:0] apply_reset(
        input logic [7:0] cur,
        input logic [7:0] keep,
        input logic [7:0] rval
    );
        return (cur & keep) | (rval & ~keep);
    endfunction : apply_reset

    //////////////////////////////////////////////////////////////////////////
    logic [7:0]          regs_q [crr_pkg::NREG];
    logic [20:0]         pc_q;
    logic [3:0]          sts_q;
    logic [3:0]          msk_q;
    crr_pkg::crr_class_t cls_d;
    logic                gie;
    logic                vec_wake;
    logic                acc;
    logic                wr_fire;
    logic [4:0]          idx;
    logic                reg_hit;
    logic                sts_hit;
    logic                msk_hit;
    logic [3:0]          sts_set;

    always_comb begin
        cls_d    = decode_class(rst_src);
        gie      = regs_q[crr_pkg::IDX_IRQ_CONTROL_MAIN][crr_pkg::GIE_HIGH_BIT]
                 | regs_q[crr_pkg::IDX_IRQ_CONTROL_MAIN][crr_pkg::GIE_LOW_BIT];
        vec_wake = (cls_d == crr_pkg::CLS_WAKE)
                 && rst_src[crr_pkg::SRC_IRQ_WAKE] && gie;
        acc      = psel && penable;
        wr_fire  = acc && pwrite && pready;
        idx      = paddr[6:2];
        // indirect ports own no storage, so they decode as unmapped
        reg_hit  = (paddr[1:0] == 2'h0) && !paddr[7]
                 && (idx < 5'(crr_pkg::NREG));
        sts_hit  = paddr == crr_pkg::ADDR_EVENT_STATUS;
        msk_hit  = paddr == crr_pkg::ADDR_EVENT_MASK;
        sts_set  = 4'h0;
        sts_set[crr_pkg::EV_POWER]  = cls_d == crr_pkg::CLS_POWER;
        sts_set[crr_pkg::EV_WARM]   = cls_d == crr_pkg::CLS_WARM;
        sts_set[crr_pkg::EV_WAKE]   = cls_d == crr_pkg::CLS_WAKE;
        sts_set[crr_pkg::EV_VECTOR] = vec_wake;
    end

    //////////////////////////////////////////////////////////////////////////
    // register bank; a reset class outranks a software write that cycle
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < crr_pkg::NREG; i++) begin
                regs_q[i] <= crr_pkg::REG_RESET[i];
            end
        end else begin
            unique case (cls_d)
                crr_pkg::CLS_POWER: begin
                    for (int i = 0; i < crr_pkg::NREG; i++) begin
                        regs_q[i] <= apply_reset(regs_q[i],
                            crr_pkg::POWER_KEEP[i],
                            crr_pkg::REG_RESET[i]);
                    end
                end
                crr_pkg::CLS_WARM: begin
                    for (int i = 0; i < crr_pkg::NREG; i++) begin
                        regs_q[i] <= apply_reset(regs_q[i],
                            crr_pkg::WARM_KEEP[i],
                            crr_pkg::REG_RESET[i]);
                    end
                end
                crr_pkg::CLS_WAKE: begin
                    // everything else holds; only cause bits and stack move
                    regs_q[crr_pkg::IDX_IRQ_CONTROL_MAIN] <=
                        regs_q[crr_pkg::IDX_IRQ_CONTROL_MAIN]
                        | wake_irq_flags;
                    if (vec_wake) begin
                        regs_q[crr_pkg::IDX_STACK_TOP_UPPER] <=
                            {3'h0, wake_pc[20:16]};
                        regs_q[crr_pkg::IDX_STACK_TOP_HIGH] <=
                            wake_pc[15:8];
                        regs_q[crr_pkg::IDX_STACK_TOP_LOW] <=
                            wake_pc[7:0];
                        regs_q[crr_pkg::IDX_RETURN_STACK_PTR][4:0] <=
                            regs_q[crr_pkg::IDX_RETURN_STACK_PTR][4:0]
                            + 5'h01;
                    end
                end
                crr_pkg::CLS_NONE: begin
                    if (wr_fire && reg_hit) begin
                        regs_q[idx] <= pwdata[7:0] & crr_pkg::REG_MASK[idx];
                    end
                end
            endcase
        end
    end

    // program counter; low byte is the software-visible part
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pc_q <= 21'h000000;
        end else begin
            unique case (cls_d)
                crr_pkg::CLS_POWER, crr_pkg::CLS_WARM: begin
                    pc_q <= 21'h000000;
                end
                crr_pkg::CLS_WAKE: begin
                    if (vec_wake) begin
                        pc_q <= wake_high_prio ? crr_pkg::VEC_HIGH
                                               : crr_pkg::VEC_LOW;
                    end else begin
                        pc_q <= wake_pc + crr_pkg::PC_STEP;
                    end
                end
                crr_pkg::CLS_NONE: begin
                    if (wr_fire && reg_hit
                        && idx == crr_pkg::IDX_PROG_COUNTER_LOW) begin
                        pc_q[7:0] <= pwdata[7:0];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pc_out    <= 21'h000000;
            class_out <= crr_pkg::CLS_NONE;
        end else begin
            pc_out    <= pc_q;
            class_out <= cls_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // event status: a set in the clearing cycle wins over the clear
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sts_q <= 4'h0;
        end else if (wr_fire && sts_hit) begin
            sts_q <= (sts_q & ~pwdata[3:0]) | sts_set;
        end else begin
            sts_q <= sts_q | sts_set;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            msk_q <= 4'h0;
        end else if (wr_fire && msk_hit) begin
            msk_q <= pwdata[3:0];
        end
    end

    // registered, so irq trails the status bit by one cycle
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(sts_q & msk_q);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // apb: one wait state, pready high in the second access cycle
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= acc && !pready;
            pslverr <= acc && !pready && !(reg_hit || sts_hit || msk_hit);
            if (acc && !pready && !pwrite) begin
                if (reg_hit && idx == crr_pkg::IDX_PROG_COUNTER_LOW) begin
                    prdata <= {24'h000000, pc_q[7:0]};
                end else if (reg_hit) begin
                    prdata <= {24'h000000, regs_q[idx]};
                end else if (sts_hit) begin
                    prdata <= {28'h0000000, sts_q};
                end else if (msk_hit) begin
                    prdata <= {28'h0000000, msk_q};
                end else begin
                    prdata <= 32'h00000000;
                end
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    class_onehot_a: assert property ($onehot(cls_d))
        else $error("class decode not one-hot");
    second_ones_a: assert property (
        (cls_d == crr_pkg::CLS_POWER || cls_d == crr_pkg::CLS_WARM)
        |=> regs_q[crr_pkg::IDX_IRQ_CONTROL_SECOND] == 8'hFF)
        else $error("irq control second not all ones");
    third_value_a: assert property (
        cls_d == crr_pkg::CLS_WARM
        |=> regs_q[crr_pkg::IDX_IRQ_CONTROL_THIRD] == 8'hC0)
        else $error("irq control third wrong after warm");
    warm_return_stack_pointer_a: assert property (
        cls_d == crr_pkg::CLS_WARM
        |=> regs_q[crr_pkg::IDX_RETURN_STACK_PTR][4:0] == 5'h00
         && regs_q[crr_pkg::IDX_RETURN_STACK_PTR][7:6]
            == $past(regs_q[crr_pkg::IDX_RETURN_STACK_PTR][7:6]))
        else $error("stack pointer warm behaviour wrong");
    power_return_stack_pointer_a: assert property (
        cls_d == crr_pkg::CLS_POWER
        |=> regs_q[crr_pkg::IDX_RETURN_STACK_PTR] == 8'h00)
        else $error("stack pointer not cleared on power");
    vector_pc_a: assert property (
        vec_wake |=> pc_q == ($past(wake_high_prio) ? crr_pkg::VEC_HIGH
                                                    : crr_pkg::VEC_LOW))
        else $error("vector not loaded");
    vector_push_a: assert property (
        vec_wake |=> regs_q[crr_pkg::IDX_STACK_TOP_LOW] == $past(wake_pc[7:0])
         && regs_q[crr_pkg::IDX_RETURN_STACK_PTR][4:0]
            == $past(regs_q[crr_pkg::IDX_RETURN_STACK_PTR][4:0]) + 5'h01)
        else $error("stack push on vectored wake wrong");
    vector_upper_a: assert property (
        vec_wake |=> regs_q[crr_pkg::IDX_STACK_TOP_HIGH]
            == $past(wake_pc[15:8])
         && regs_q[crr_pkg::IDX_STACK_TOP_UPPER]
            == {3'h0, $past(wake_pc[20:16])})
        else $error("stack top not pushed");
    plain_stack_a: assert property (
        cls_d == crr_pkg::CLS_WAKE && !vec_wake
        |=> $stable(regs_q[crr_pkg::IDX_RETURN_STACK_PTR])
         && $stable(regs_q[crr_pkg::IDX_STACK_TOP_UPPER]))
        else $error("plain wake moved the stack");
    wake_pc_a: assert property (
        cls_d == crr_pkg::CLS_WAKE && !vec_wake
        |=> pc_q == $past(wake_pc) + crr_pkg::PC_STEP)
        else $error("wake pc not plus two");
    class_pc_a: assert property (
        cls_d == crr_pkg::CLS_POWER ##1 cls_d == crr_pkg::CLS_NONE
        |=> pc_q == 21'h000000 ##1 pc_out == 21'h000000)
        else $error("pc not cleared by power class");
    reset_pc_a: assert property (
        cls_d == crr_pkg::CLS_WARM
        |=> pc_q == 21'h000000)
        else $error("pc not cleared by warm class");
    wake_keep_a: assert property (
        cls_d == crr_pkg::CLS_WAKE
        |=> $stable(regs_q[crr_pkg::IDX_TABLE_PTR_HIGH])
         && $stable(regs_q[crr_pkg::IDX_IRQ_CONTROL_SECOND]))
        else $error("wake disturbed held register");
    wake_hold_a: assert property (
        cls_d == crr_pkg::CLS_WAKE
        |=> $stable(regs_q[crr_pkg::IDX_IRQ_CONTROL_THIRD])
         && $stable(regs_q[crr_pkg::IDX_PC_LATCH_UPPER]))
        else $error("wake disturbed control or latch");
    warm_keep_a: assert property (
        cls_d == crr_pkg::CLS_WARM
        |=> $stable(regs_q[crr_pkg::IDX_WORKING_ACC]))
        else $error("working register lost on warm");
    power_keep_a: assert property (
        cls_d == crr_pkg::CLS_POWER
        |=> $stable(regs_q[crr_pkg::IDX_WORKING_ACC]))
        else $error("working register moved on power");
    ptr_high_a: assert property (
        cls_d == crr_pkg::CLS_WARM
        |=> regs_q[crr_pkg::IDX_INDIRECT_PTR0_HIGH] == 8'h00)
        else $error("pointer high not cleared");
    upper_clear_a: assert property (
        cls_d == crr_pkg::CLS_POWER
        |=> regs_q[crr_pkg::IDX_STACK_TOP_UPPER] == 8'h00
         && regs_q[crr_pkg::IDX_PC_LATCH_UPPER] == 8'h00
         && regs_q[crr_pkg::IDX_INDIRECT_PTR0_HIGH] == 8'h00)
        else $error("upper fields not cleared on power");
    table_clear_a: assert property (
        (cls_d == crr_pkg::CLS_POWER || cls_d == crr_pkg::CLS_WARM)
        |=> regs_q[crr_pkg::IDX_TABLE_PTR_HIGH] == 8'h00
         && regs_q[crr_pkg::IDX_PC_LATCH_HIGH] == 8'h00)
        else $error("table pointer or latch not cleared");
    main_bits_a: assert property (
        cls_d == crr_pkg::CLS_WARM
        |=> regs_q[crr_pkg::IDX_IRQ_CONTROL_MAIN] ==
            ($past(regs_q[crr_pkg::IDX_IRQ_CONTROL_MAIN]) & 8'h01))
        else $error("irq control main warm value wrong");
    power_main_a: assert property (
        cls_d == crr_pkg::CLS_POWER
        |=> regs_q[crr_pkg::IDX_IRQ_CONTROL_MAIN][7:1] == 7'h00)
        else $error("irq control main not cleared");
    wake_cause_a: assert property (
        cls_d == crr_pkg::CLS_WAKE
        |=> regs_q[crr_pkg::IDX_IRQ_CONTROL_MAIN] ==
            ($past(regs_q[crr_pkg::IDX_IRQ_CONTROL_MAIN])
             | $past(wake_irq_flags)))
        else $error("wake cause bits not recorded");
    status_set_a: assert property (
        cls_d == crr_pkg::CLS_WAKE
        |=> sts_q[crr_pkg::EV_WAKE])
        else $error("wake event not in status");
    ready_once_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    unmapped_err_a: assert property (
        acc && !pready && !(reg_hit || sts_hit || msk_hit)
        |=> pslverr && prdata == 32'h00000000)
        else $error("unmapped access not refused");

    vector_wake_c: cover property (vec_wake);
    plain_wake_c: cover property (cls_d == crr_pkg::CLS_WAKE && !vec_wake);
    warm_then_read_c: cover property (
        cls_d == crr_pkg::CLS_WARM ##[1:20] (acc && pready && !pwrite));
    power_class_c: cover property (cls_d == crr_pkg::CLS_POWER);
    irq_raise_c: cover property ($rose(irq));

endmodule : crr_core_regs

`default_nettype wire

/* File: bench/crr_core_model.sv */
// far-side core model: drives reset and wake sources into the bank
`timescale 1ns/1ps
`default_nettype none
module crr_core_model (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        fire,
    input  wire logic [10:0] src,
    input  wire logic [20:0] pc_in,
    input  wire logic        prio_in,
    input  wire logic [7:0]  flags_in,
    output logic      [10:0] rst_src,
    output logic      [20:0] wake_pc,
    output logic             wake_high_prio,
    output logic      [7:0]  wake_irq_flags
);
    //////////////////////////////////////////////////////////////////////////
    // outside a pulse the side lines toggle, so stale values never help
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_src        <= 11'h000;
            wake_pc        <= 21'h000000;
            wake_high_prio <= 1'b0;
            wake_irq_flags <= 8'h00;
        end else begin
            rst_src        <= fire ? src : 11'h000;
            wake_pc        <= fire ? pc_in : ~wake_pc;
            wake_high_prio <= fire ? prio_in : ~wake_high_prio;
            wake_irq_flags <= fire ? flags_in : ~wake_irq_flags;
        end
    end
endmodule : crr_core_model
`default_nettype wire

/* File: bench/crr_core_regs_tb.sv */
// self-checking bench for the core register reset bank
`timescale 1ns/1ps
`default_nettype none
`define crr_chk(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
    err_count++; $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module crr_core_regs_tb;
    logic                core_clk, nrst, psel, penable, pwrite;
    logic                pready, pslverr, irq, fire, prio_in, wake_high_prio;
    logic [7:0]          paddr, flags_in, wake_irq_flags;
    logic [31:0]         pwdata, prdata, rnd;
    logic [10:0]         rst_src, src;
    logic [20:0]         wake_pc, pc_in, pc_out;
    crr_pkg::crr_class_t class_out;
    logic [7:0]          exp_q [crr_pkg::NREG];
    logic [33:0]         bus_q [$];
    logic [24:0]         cls_q [$];
    logic [33:0]         be;
    logic [24:0]         ce;
    int                  err_count, comparisons;
    logic                pc_pend = 1'b0;
    logic [20:0]         pc_exp;

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    crr_core_regs dut (.core_clk(core_clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rst_src(rst_src), .wake_pc(wake_pc), .wake_high_prio(wake_high_prio),
        .wake_irq_flags(wake_irq_flags), .pc_out(pc_out),
        .class_out(class_out), .irq(irq));
    crr_core_model core (.core_clk(core_clk), .nrst(nrst), .fire(fire),
        .src(src), .pc_in(pc_in), .prio_in(prio_in), .flags_in(flags_in),
        .rst_src(rst_src), .wake_pc(wake_pc), .wake_high_prio(wake_high_prio),
        .wake_irq_flags(wake_irq_flags));

    //////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("errors=%0d comparisons=%0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // one idle edge after each transfer keeps psel from double assignment
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic [31:0] ed,
                       input logic ee);
        int n;
        n = 0;
        bus_q.push_back({~wr, ed, ee});
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_count++;
            final_report();
        end
        penable <= 1'b0;
        psel    <= 1'b0;
        @(posedge core_clk);
    endtask : apb

    task automatic wr(input int i, input logic [7:0] v);
        exp_q[i] = v & crr_pkg::REG_MASK[i];
        apb(1'b1, 8'(i * 4), {24'h000000, v}, 32'h00000000, 1'b0);
    endtask : wr

    task automatic check_all;
        for (int i = 0; i < crr_pkg::NREG; i++) begin
            apb(1'b0, 8'(i * 4), 32'h00000000, {24'h000000, exp_q[i]}, 1'b0);
        end
    endtask : check_all

    task automatic pulse(input logic [10:0] s, input logic [20:0] pc,
                         input logic p, input logic [7:0] f);
        logic [20:0]         npc;
        logic                pw;
        logic                vec;
        logic [7:0]          k;
        crr_pkg::crr_class_t c;
        npc = 21'h000000;
        pw  = |(s & crr_pkg::POWER_SRC_MASK);
        if (pw || |(s & crr_pkg::WARM_SRC_MASK)) begin
            c = pw ? crr_pkg::CLS_POWER : crr_pkg::CLS_WARM;
            foreach (exp_q[i]) begin
                k = pw ? crr_pkg::POWER_KEEP[i] : crr_pkg::WARM_KEEP[i];
                exp_q[i] = (exp_q[i] & k) | (crr_pkg::REG_RESET[i] & ~k);
            end
        end else begin
            c   = crr_pkg::CLS_WAKE;
            vec = s[crr_pkg::SRC_IRQ_WAKE] && |exp_q[13][7:6];
            npc = pc + crr_pkg::PC_STEP;
            if (vec) begin
                npc = p ? crr_pkg::VEC_HIGH : crr_pkg::VEC_LOW;
                exp_q[0] = {3'h0, pc[20:16]};
                exp_q[1] = pc[15:8];
                exp_q[2] = pc[7:0];
                exp_q[3][4:0] = exp_q[3][4:0] + 5'h01;
            end
            exp_q[6]  = npc[7:0];
            exp_q[13] = exp_q[13] | f;
        end
        cls_q.push_back({c, npc});
        src      <= s;
        pc_in    <= pc;
        prio_in  <= p;
        flags_in <= f;
        fire     <= 1'b1;
        @(posedge core_clk);
        fire <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask : pulse

    //////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            be = bus_q.pop_front();
            if (be[33]) `crr_chk(prdata, be[32:1])
            `crr_chk(pslverr, be[0])
        end
        // pc_out trails class_out by one edge
        if (pc_pend) begin
            `crr_chk(pc_out, pc_exp)
            pc_pend = 1'b0;
        end
        if (nrst === 1'b1 && class_out !== crr_pkg::CLS_NONE) begin
            ce = cls_q.pop_front();
            `crr_chk(class_out, ce[24:21])
            pc_exp  = ce[20:0];
            pc_pend = 1'b1;
        end
    end

    initial begin
        {nrst, psel, penable, pwrite, fire, prio_in} = 6'h00;
        {paddr, pwdata, src, pc_in, flags_in} = 0;
        err_count   = 0;
        comparisons = 0;
        rnd = 32'h00017F4C;
        foreach (exp_q[i]) exp_q[i] = crr_pkg::REG_RESET[i];
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        check_all();
        apb(1'b0, 8'h58, 32'h00000000, 32'h00000000, 1'b1);
        apb(1'b1, 8'h58, 32'hFFFFFFFF, 32'h00000000, 1'b1);
        // three passes: gie high, gie low, none, so vectoring is exercised
        for (int p = 0; p < 3; p++) begin
            for (int s = 0; s < crr_pkg::NSRC; s++) begin
                for (int i = 0; i < crr_pkg::NREG; i++) begin
                    rnd = lfsr(rnd);
                    wr(i, rnd[7:0]);
                end
                if (s == crr_pkg::SRC_IRQ_WAKE) begin
                    wr(13, {p == 0, p == 1, exp_q[13][5:0]});
                    if (p == 0) wr(3, 8'hDF); // pointer wraps 31 to 0
                end
                rnd = lfsr(rnd);
                pulse(11'h001 << s, rnd[20:0], rnd[21], rnd[29:22] & 8'h3F);
                check_all();
            end
        end
        pulse(11'h401, 21'h012345, 1'b1, 8'h05);
        pulse(11'h208, 21'h054321, 1'b0, 8'h0A);
        check_all();
        apb(1'b1, crr_pkg::ADDR_EVENT_MASK, 32'h0, 32'h0, 1'b0);
        apb(1'b1, crr_pkg::ADDR_EVENT_STATUS, 32'hF, 32'h0, 1'b0);
        apb(1'b0, crr_pkg::ADDR_EVENT_STATUS, 32'h0, 32'h0, 1'b0);
        pulse(11'h008, 21'h000000, 1'b0, 8'h00);
        apb(1'b0, crr_pkg::ADDR_EVENT_STATUS, 32'h0, 32'h2, 1'b0);
        `crr_chk(irq, 1'b0)
        apb(1'b1, crr_pkg::ADDR_EVENT_MASK, 32'h2, 32'h0, 1'b0);
        repeat (2) @(posedge core_clk);
        `crr_chk(irq, 1'b1)
        apb(1'b1, crr_pkg::ADDR_EVENT_STATUS, 32'h2, 32'h0, 1'b0);
        repeat (2) @(posedge core_clk);
        `crr_chk(irq, 1'b0)
        nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        foreach (exp_q[i]) exp_q[i] = crr_pkg::REG_RESET[i];
        nrst <= 1'b1;
        @(posedge core_clk);
        check_all();
        `crr_chk(cls_q.size(), 0)
        `crr_chk(bus_q.size(), 0)
        final_report();
    end
endmodule : crr_core_regs_tb
`default_nettype wire
